/* File: verilog/adc_fmt_pkg.sv */
package adc_fmt_pkg;

  // ---------------------------------------------------------------
  // word and pipeline
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W  = 14;
  localparam int unsigned WORD_W  = DATA_W + 1; // range flag on top
  localparam int unsigned LATENCY = 7;          // encode cycles

  // ---------------------------------------------------------------
  // register map, byte addresses
  // ---------------------------------------------------------------
  localparam int unsigned ADR_W         = 8;
  localparam logic [7:0]  OFF_CTRL      = 8'h00;
  localparam logic [7:0]  OFF_IRQ_STAT  = 8'h04;
  localparam logic [7:0]  OFF_IRQ_CLR   = 8'h08;
  localparam logic [7:0]  OFF_IRQ_EN    = 8'h0c;
  localparam logic [7:0]  OFF_LAST_WORD = 8'h10;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int unsigned CTL_W        = 7;
  localparam int unsigned CTL_MODE_LSB = 0;
  localparam int unsigned CTL_FMT_LSB  = 2;
  localparam int unsigned CTL_PD_BIT   = 4;
  localparam int unsigned CTL_DITHER_ENABLE_IN_BIT = 5;
  localparam int unsigned CTL_RANDOMIZER_ENABLE_IN_BIT = 6;
  localparam logic [6:0]  CTL_RESET    = 7'h00;

  // output interface codes (strap level 0, 1/3, 2/3, full)
  localparam logic [1:0] MODE_FULL     = 2'h0;
  localparam logic [1:0] MODE_DEMUX    = 2'h1;
  localparam logic [1:0] MODE_LP_DIFF  = 2'h2;
  localparam logic [1:0] MODE_STD_DIFF = 2'h3;

  // format codes (strap level 0, 1/3, 2/3, full)
  localparam logic [1:0] FMT_OB_NOSTAB = 2'h0;
  localparam logic [1:0] FMT_OB_STAB   = 2'h1;
  localparam logic [1:0] FMT_TC_STAB   = 2'h2;
  localparam logic [1:0] FMT_TC_NOSTAB = 2'h3;

  // ---------------------------------------------------------------
  // interrupt events
  // ---------------------------------------------------------------
  localparam int unsigned EV_W     = 2;
  localparam int unsigned EV_WORD  = 0;
  localparam int unsigned EV_RANGE = 1;
  localparam logic [1:0]  EV_RESET = 2'h0;

endpackage

/* File: verilog/level_sync.sv */
`timescale 1ns/1ps

// two-stage synchroniser for asynchronous levels
module level_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // levels
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule

/* File: verilog/adc_output_formatter.sv */
`timescale 1ns/1ps

module adc_output_formatter (
  // system
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // wishbone slave
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [adc_fmt_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  output logic                               irq_o,
  // encode pair and converter core
  input  wire logic                          encode_clock_pos_i,
  input  wire logic                          encode_clock_neg_i,
  input  wire logic [13:0]                   core_sample_i,
  input  wire logic                          core_range_i,
  // single-ended buses
  output logic      [13:0]                   primary_data_bus_o,
  output logic                               primary_range_flag_o,
  output logic                               primary_oe_o,
  output logic      [13:0]                   secondary_data_bus_o,
  output logic                               secondary_range_flag_o,
  output logic                               secondary_oe_o,
  output logic                               valid_clock_true_o,
  output logic                               valid_clock_inverted_o,
  // differential outputs
  output logic      [13:0]                   diff_data_pairs_p_o,
  output logic      [13:0]                   diff_data_pairs_n_o,
  output logic                               diff_valid_clock_p_o,
  output logic                               diff_valid_clock_n_o,
  output logic                               diff_range_flag_p_o,
  output logic                               diff_range_flag_n_o,
  output logic                               diff_oe_o,
  output logic                               diff_low_power_o,
  // analog controls
  output logic                               analog_power_down_o,
  output logic                               dither_active_o,
  output logic                               stabilizer_on_o
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  localparam int unsigned DW = adc_fmt_pkg::DATA_W;
  localparam int unsigned PIPE_N = adc_fmt_pkg::LATENCY;
  logic [1:0]                      enc_s;
  logic                            enc_high_q;
  logic [adc_fmt_pkg::WORD_W-1:0]  pipe_q [PIPE_N];
  logic [adc_fmt_pkg::CTL_W-1:0]   ctrl_q, ctrl_d;
  logic [adc_fmt_pkg::EV_W-1:0]    status_q, status_d;
  logic [adc_fmt_pkg::EV_W-1:0]    irq_en_q, irq_en_d;
  logic [adc_fmt_pkg::WORD_W-1:0]  last_q;
  logic                            ack_q, irq_q;
  logic [31:0]                     rdata_q;
  logic                            phase_q;
  logic                            vt_q, vi_q, vt_d;
  logic [DW-1:0]                   pri_q, sec_q, dp_q, dn_q;
  logic                            pri_rng_q, sec_rng_q, fp_q, fn_q;
  logic                            pri_oe_q, sec_oe_q, diff_oe_q;
  logic                            lp_q, apd_q, dither_enable_in_q, stab_q;

  // ---------------------------------------------------------------
  // encode edge detection
  // ---------------------------------------------------------------
  level_sync #(
    .WIDTH (2)
  ) u_enc_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({encode_clock_pos_i, encode_clock_neg_i}),
    .q_o   (enc_s)
  );

  // encode is high while the true leg is above the complement leg
  wire enc_high = enc_s[1] & ~enc_s[0];
  wire enc_rise = enc_high & ~enc_high_q;
  wire enc_fall = ~enc_high & enc_high_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) enc_high_q <= 1'b0;
    else       enc_high_q <= enc_high;
  end

  // ---------------------------------------------------------------
  // control decode
  // ---------------------------------------------------------------
  wire [1:0] mode_c   = ctrl_q[adc_fmt_pkg::CTL_MODE_LSB +: 2];
  wire [1:0] fmt_c    = ctrl_q[adc_fmt_pkg::CTL_FMT_LSB +: 2];
  wire       pd       = ctrl_q[adc_fmt_pkg::CTL_PD_BIT];
  wire       randomizer_enable_in_on  = ctrl_q[adc_fmt_pkg::CTL_RANDOMIZER_ENABLE_IN_BIT];
  wire       is_full  = (mode_c == adc_fmt_pkg::MODE_FULL);
  wire       is_demux = (mode_c == adc_fmt_pkg::MODE_DEMUX);
  wire       is_lp    = (mode_c == adc_fmt_pkg::MODE_LP_DIFF);
  wire       is_diff  = is_lp | (mode_c == adc_fmt_pkg::MODE_STD_DIFF);
  wire       twos     = (fmt_c == adc_fmt_pkg::FMT_TC_STAB) |
                        (fmt_c == adc_fmt_pkg::FMT_TC_NOSTAB);
  wire       stab     = (fmt_c == adc_fmt_pkg::FMT_OB_STAB) |
                        (fmt_c == adc_fmt_pkg::FMT_TC_STAB);
  // no capture while powered down: the analog core is off
  wire update   = enc_rise & ~pd;

  // ---------------------------------------------------------------
  // pipeline and word formatting
  // ---------------------------------------------------------------
  // capture on encode rise, shift one stage per encode cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < PIPE_N; i++) pipe_q[i] <= '0;
    end else if (update) begin
      pipe_q[0] <= {core_range_i, core_sample_i};
      for (int i = 1; i < PIPE_N; i++) pipe_q[i] <= pipe_q[i-1];
    end
  end

  wire [DW-1:0] raw_word = pipe_q[PIPE_N-1][DW-1:0];
  wire          out_rng  = pipe_q[PIPE_N-1][DW];
  // two's complement is offset binary with the msb flipped
  wire [DW-1:0] fmt_word = twos ? {~raw_word[DW-1], raw_word[DW-2:0]}
                                : raw_word;
  // bit 0 stays plain so the receiver can undo the xor
  wire [DW-1:0] out_word = randomizer_enable_in_on ?
    {fmt_word[DW-1:1] ^ {(DW-1){fmt_word[0]}}, fmt_word[0]} :
    fmt_word;
  // demuxed mode: even samples to primary, odd to secondary
  wire pri_load = ~is_diff & (~is_demux | ~phase_q);
  wire sec_load = is_demux & phase_q;

  // ---------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------
  // single-ended data, range flags and differential pairs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pri_q     <= '0;
      pri_rng_q <= 1'b0;
      sec_q     <= '0;
      sec_rng_q <= 1'b0;
      dp_q      <= '0;
      dn_q      <= '1;
      fp_q      <= 1'b0;
      fn_q      <= 1'b1;
      phase_q   <= 1'b0;
    end else if (update) begin
      if (pri_load) begin
        pri_q     <= out_word;
        pri_rng_q <= out_rng;
      end
      if (sec_load) begin
        sec_q     <= out_word;
        sec_rng_q <= out_rng;
      end
      if (is_diff) begin
        dp_q <= out_word;
        dn_q <= ~out_word;
        fp_q <= out_rng;
        fn_q <= ~out_rng;
      end
      phase_q <= is_demux & ~phase_q;
    end
  end

  // full rate: follows encode; demuxed: moves on falls, buses settled
  assign vt_d = pd ? 1'b0 :
                is_demux ? (enc_fall ? ~phase_q : vt_q) :
                enc_rise ? 1'b1 :
                enc_fall ? 1'b0 : vt_q;
  // valid clocks, drive enables and analog controls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vt_q      <= 1'b0;
      vi_q      <= 1'b1;
      pri_oe_q  <= 1'b0;
      sec_oe_q  <= 1'b0;
      diff_oe_q <= 1'b0;
      lp_q      <= 1'b0;
      apd_q     <= 1'b0;
      dither_enable_in_q    <= 1'b0;
      stab_q    <= 1'b0;
    end else begin
      vt_q      <= vt_d;
      vi_q      <= ~vt_d;
      pri_oe_q  <= ~pd & ~is_diff;
      sec_oe_q  <= ~pd & is_demux;
      diff_oe_q <= ~pd & is_diff;
      lp_q      <= is_lp;
      apd_q     <= pd;
      dither_enable_in_q    <= ctrl_q[adc_fmt_pkg::CTL_DITHER_ENABLE_IN_BIT] & ~pd;
      stab_q    <= stab;
    end
  end

  // ---------------------------------------------------------------
  // wishbone register file
  // ---------------------------------------------------------------
  // one wait state: ack follows the request by one clock
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
  wire hit_ctl = (wb_adr_i == adc_fmt_pkg::OFF_CTRL);
  wire hit_st  = (wb_adr_i == adc_fmt_pkg::OFF_IRQ_STAT);
  wire hit_clr = (wb_adr_i == adc_fmt_pkg::OFF_IRQ_CLR);
  wire hit_en  = (wb_adr_i == adc_fmt_pkg::OFF_IRQ_EN);
  wire hit_lw  = (wb_adr_i == adc_fmt_pkg::OFF_LAST_WORD);
  wire [adc_fmt_pkg::EV_W-1:0] events  = {update & out_rng, update};
  wire [adc_fmt_pkg::EV_W-1:0] clr_msk = (bus_wr & hit_clr) ?
    wb_dat_i[adc_fmt_pkg::EV_W-1:0] : '0;
  assign ctrl_d   = (bus_wr & hit_ctl) ?
                    wb_dat_i[adc_fmt_pkg::CTL_W-1:0] : ctrl_q;
  assign irq_en_d = (bus_wr & hit_en) ?
                    wb_dat_i[adc_fmt_pkg::EV_W-1:0] : irq_en_q;
  // a new event beats a clear in the same cycle
  assign status_d = (status_q & ~clr_msk) | events;
  // unmapped and write-only addresses read as zero
  wire [31:0] rd_mux =
    hit_ctl ? {{(32-adc_fmt_pkg::CTL_W){1'b0}}, ctrl_q}  :
    hit_st  ? {{(32-adc_fmt_pkg::EV_W){1'b0}}, status_q} :
    hit_en  ? {{(32-adc_fmt_pkg::EV_W){1'b0}}, irq_en_q} :
    hit_lw  ? {{(32-adc_fmt_pkg::WORD_W){1'b0}}, last_q} : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q   <= adc_fmt_pkg::CTL_RESET;
      irq_en_q <= adc_fmt_pkg::EV_RESET;
      status_q <= adc_fmt_pkg::EV_RESET;
      last_q   <= '0;
      ack_q    <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      irq_q    <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      irq_en_q <= irq_en_d;
      status_q <= status_d;
      if (update) last_q <= {out_rng, out_word};
      ack_q    <= bus_req;
      rdata_q  <= bus_req ? rd_mux : 32'h0000_0000;
      irq_q    <= |(status_d & irq_en_d);
    end
  end

  // ---------------------------------------------------------------
  // port drive
  // ---------------------------------------------------------------
  assign wb_dat_o               = rdata_q;
  assign wb_ack_o               = ack_q;
  assign irq_o                  = irq_q;
  assign primary_data_bus_o     = pri_q;
  assign primary_range_flag_o   = pri_rng_q;
  assign primary_oe_o           = pri_oe_q;
  assign secondary_data_bus_o   = sec_q;
  assign secondary_range_flag_o = sec_rng_q;
  assign secondary_oe_o         = sec_oe_q;
  assign valid_clock_true_o     = vt_q;
  assign valid_clock_inverted_o = vi_q;
  assign diff_data_pairs_p_o    = dp_q;
  assign diff_data_pairs_n_o    = dn_q;
  assign diff_valid_clock_p_o   = vt_q;
  assign diff_valid_clock_n_o   = vi_q;
  assign diff_range_flag_p_o    = fp_q;
  assign diff_range_flag_n_o    = fn_q;
  assign diff_oe_o              = diff_oe_q;
  assign diff_low_power_o       = lp_q;
  assign analog_power_down_o    = apd_q;
  assign dither_active_o        = dither_enable_in_q;
  assign stabilizer_on_o        = stab_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_update;
    enc_rise && !pd;
  endsequence
  a_capture_sample: assert property (
    s_update |=> pipe_q[0] == $past({core_range_i, core_sample_i}))
    else $error("sample not captured on encode rise");
  a_pipe_advance: assert property (
    s_update |=> pipe_q[PIPE_N-1] == $past(pipe_q[PIPE_N-2]))
    else $error("pipeline did not advance one stage");
  a_power_down_hiz: assert property (
    pd |=> !primary_oe_o && !secondary_oe_o && !diff_oe_o)
    else $error("outputs driven during power down");
  a_dither_follow: assert property (
    1'b1 |=> dither_active_o ==
      $past(ctrl_q[adc_fmt_pkg::CTL_DITHER_ENABLE_IN_BIT] & ~pd))
    else $error("dither does not follow enable");
  a_primary_word: assert property (
    s_update ##0 pri_load |=> primary_data_bus_o == $past(out_word) &&
      primary_range_flag_o == $past(out_rng))
    else $error("primary bus word or flag wrong");
  a_secondary_hiz: assert property (
    !is_demux |=> !secondary_oe_o)
    else $error("secondary bus driven outside demuxed mode");
  a_demux_alternate: assert property (
    s_update ##0 (is_demux && phase_q) |=> $stable(primary_data_bus_o) &&
      secondary_data_bus_o == $past(out_word) && !phase_q)
    else $error("demuxed samples not alternating");
  a_full_rate_clock: assert property (
    s_update ##0 is_full |=> valid_clock_true_o)
    else $error("valid clock did not rise with new word");
  a_valid_inverted: assert property (
    valid_clock_inverted_o == !valid_clock_true_o)
    else $error("inverted valid clock not complementary");
  a_diff_range: assert property (
    s_update ##0 is_diff |=> diff_range_flag_p_o == $past(out_rng) &&
      diff_range_flag_n_o != diff_range_flag_p_o &&
      diff_data_pairs_n_o == ~diff_data_pairs_p_o)
    else $error("differential word or flag wrong");
  a_randomize: assert property (
    s_update ##0 (pri_load && randomizer_enable_in_on) |=>
      primary_data_bus_o[DW-1:1] ==
      ($past(fmt_word[DW-1:1]) ^ {(DW-1){$past(fmt_word[0])}}))
    else $error("randomizer xor wrong");
endmodule

/* File: sim/capture_model.sv */
`timescale 1ns/1ps

// --------
// receiving capture logic
// --------
module capture_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // output stage pins
  input  wire logic        vclk_i,
  input  wire logic        vclk_n_i,
  input  wire logic [13:0] bus_i,
  input  wire logic        randomizer_enable_in_i,
  // recovered word
  output logic      [13:0] word_o
);
  logic prev_q;

  // latch on true clock fall, seen as the inverted clock rise
  always_ff @(posedge clk_i) begin
    prev_q <= vclk_i;
    if (rst_i) begin
      word_o <= 14'h0000;
    end else if (prev_q && !vclk_i && vclk_n_i) begin
      word_o <= randomizer_enable_in_i ? bus_i ^ {{13{bus_i[0]}}, 1'b0} : bus_i;
    end
  end
endmodule

/* File: sim/adc_output_formatter_tb.sv */
`timescale 1ns/1ps

module adc_output_formatter_tb;
  // --------
  // pins and bookkeeping
  // --------
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        req = 1'b0;
  logic        we = 1'b0;
  logic        enc = 1'b0;
  logic        rng = 1'b0;
  logic        p_randomizer_enable_in = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [7:0]  adr = 8'h00;
  logic [13:0] smp = 14'h0000;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, rdo;
  logic [13:0] pb, sb, dp, dn, cap;
  logic        ack, irq, pf, sf, po, so, vt, vi, dfp, doe, dlp, apd, dth, stb;
  logic        dfn, dvp, dvn;
  int          n_fail = 0;
  int          checked = 0;
  logic [14:0] hist[$];

  always #12.5 clk_i = ~clk_i;

  // encode driven as a complementary pair, like a differential source
  adc_output_formatter u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdo), .wb_ack_o(ack), .irq_o(irq),
    .encode_clock_pos_i(enc), .encode_clock_neg_i(~enc),
    .core_sample_i(smp), .core_range_i(rng),
    .primary_data_bus_o(pb), .primary_range_flag_o(pf), .primary_oe_o(po),
    .secondary_data_bus_o(sb), .secondary_range_flag_o(sf),
    .secondary_oe_o(so), .valid_clock_true_o(vt),
    .valid_clock_inverted_o(vi), .diff_data_pairs_p_o(dp),
    .diff_data_pairs_n_o(dn), .diff_valid_clock_p_o(dvp),
    .diff_valid_clock_n_o(dvn), .diff_range_flag_p_o(dfp),
    .diff_range_flag_n_o(dfn), .diff_oe_o(doe), .diff_low_power_o(dlp),
    .analog_power_down_o(apd), .dither_active_o(dth), .stabilizer_on_o(stb)
  );

  capture_model u_cap (
    .clk_i(clk_i), .rst_i(rst_i), .vclk_i(vt), .vclk_n_i(vi),
    .bus_i(pb), .randomizer_enable_in_i(p_randomizer_enable_in), .word_o(cap)
  );

  // --------
  // helpers
  // --------
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    req  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rdat = rdo;
    req  <= 1'b0;
    // one more edge so outputs registered from control show the write
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask

  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0, 4'hf);
  endtask

  // coding first, then the lsb scramble
  function automatic logic [13:0] fmt(input logic [13:0] s,
                                      input logic tc, input logic rn);
    logic [13:0] w;
    w = s ^ {tc, 13'h0000};
    return rn ? w ^ {{13{w[0]}}, 1'b0} : w;
  endfunction

  // n encode periods of 8 clocks; early words are stale pipeline
  task automatic stream(input int n, input logic tc, input logic rn,
                        input logic [1:0] md);
    logic [14:0] h;
    logic [13:0] e;
    hist.delete();
    for (int i = 0; i < n; i++) begin
      h = {i % 3 == 0, 14'h0b57 * i[13:0] + 14'h02c3};
      @(posedge clk_i);
      if (md == 2'h0 && i >= 8)
        check("enc latch", pb, fmt(hist[i-8][13:0], tc, rn));
      enc <= 1'b1;
      smp <= h[13:0];
      rng <= h[14];
      hist.push_back(h);
      repeat (4) @(posedge clk_i);
      enc <= 1'b0;
      repeat (2) @(posedge clk_i);
      if (i >= 7) begin
        h = hist[i-7];
        e = fmt(h[13:0], tc, rn);
        check("vclk", {vt, vi}, {2{md == 1 && i[0]}} ^ 2'b10);
        if (md[1]) begin
          check("diff p", dp, e);
          check("diff n", dn ^ e, 14'h3fff);
          check("diff ovr", dfp, h[14]);
          check("diff ovr n", dfn, !h[14]);
          check("diff clk", {dvp, dvn}, 2'b10);
        end else if (md == 1 && i[0]) begin
          check("sec bus", sb, e);
          check("sec ovr", sf, h[14]);
        end else begin
          check("pri bus", pb, e);
          check("pri ovr", pf, h[14]);
        end
      end
      @(posedge clk_i);
    end
  endtask

  // --------
  // scenarios
  // --------
  task automatic s_full();
    wr(8'h00, 32'h0);
    check("oe", {po, so, doe}, 3'b100);
    stream(10, 1'b0, 1'b0, 2'h0);
    rd(8'h10);
    check("last", rdat, {hist[2][14], fmt(hist[2][13:0], 0, 0)});
  endtask

  task automatic s_formats();
    for (int f = 0; f < 4; f++) begin
      wr(8'h00, f << 2);
      check("stab", stb, f == 1 || f == 2);
      stream(9, f[1], 1'b0, 2'h0);
    end
  endtask

  // demux is entered from full rate so its phase starts clean
  task automatic s_modes();
    logic [3:0] oe;
    for (int m = 1; m < 4; m++) begin
      oe = (m == 1) ? 4'hc : (m == 2) ? 4'h3 : 4'h2;
      wr(8'h00, m);
      check("oe", {po, so, doe, dlp}, oe);
      stream(10, 1'b0, 1'b0, m[1:0]);
    end
  endtask

  task automatic s_randomizer_enable_in();
    p_randomizer_enable_in <= 1'b1;
    wr(8'h00, 32'h48);
    stream(9, 1'b1, 1'b1, 2'h0);
    repeat (4) @(posedge clk_i);
    check("capture", cap, fmt(hist[1][13:0], 1'b1, 1'b0));
    p_randomizer_enable_in <= 1'b0;
  endtask

  task automatic s_irq();
    wr(8'h00, 32'h0);
    wr(8'h0c, 32'h0);
    wr(8'h08, 32'h3);
    stream(9, 1'b0, 1'b0, 2'h0);
    rd(8'h04);
    check("status", rdat, 32'h3);
    check("irq masked", irq, 1'b0);
    wr(8'h0c, 32'h3);
    check("irq on", irq, 1'b1);
    wr(8'h08, 32'h1);
    rd(8'h04);
    check("part clear", rdat, 32'h2);
    wr(8'h08, 32'h2);
    check("irq off", irq, 1'b0);
    rd(8'h14);
    check("unmapped", rdat, 32'h0);
  endtask

  // a write without sel[0] must leave control untouched
  task automatic s_power();
    wr(8'h00, 32'h20);
    check("dither", dth, 1'b1);
    wb(1'b1, 8'h00, 32'h10, 4'he);
    check("sel0 off", apd, 1'b0);
    wr(8'h00, 32'h30);
    check("pd", {apd, po, so, doe}, 4'h8);
    wr(8'h00, 32'h0);
    check("wake", {apd, po, dth}, 3'b010);
  endtask

  task automatic tally_and_finish();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    s_full();
    s_formats();
    s_modes();
    s_randomizer_enable_in();
    s_irq();
    s_power();
    tally_and_finish();
  end

  // hang guard, well past the expected run length
  initial begin
    repeat (6000) @(posedge clk_i);
    n_fail++;
    tally_and_finish();
  end
endmodule
